// ### pmr_defs.svh
// Register offsets, field positions, reset values and fixed codes of the PHY mode select block
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// Register offsets on the serial register port (6-bit address)
`define PMR_ADDR_STATE 6'h01
`define PMR_ADDR_RSSI 6'h06
`define PMR_ADDR_ED 6'h07
`define PMR_ADDR_MODCTRL 6'h0C

// Modulation control fields and reset value
`define PMR_MODCTRL_RST 8'h24
`define PMR_BIT_SCR 5
`define PMR_BIT_ALT 4
`define PMR_BIT_MOD 3
`define PMR_BIT_FAM 2
`define PMR_RATE_HI 1
`define PMR_RATE_LO 0

// Receive status fields
`define PMR_BIT_FCS_OK 7

// Transceiver state report codes
`define PMR_STATE_OFF 5'h02
`define PMR_STATE_LISTEN 5'h04
`define PMR_STATE_BUSY 5'h01

// Serial command byte codes
`define PMR_CMD_RD 2'h2
`define PMR_CMD_WR 2'h3
`define PMR_CMD_FRM 3'h1

// Payload data rates in kb/s
`define PMR_KBPS_20 10'h014
`define PMR_KBPS_40 10'h028
`define PMR_KBPS_100 10'h064
`define PMR_KBPS_200 10'h0C8
`define PMR_KBPS_250 10'h0FA
`define PMR_KBPS_400 10'h190
`define PMR_KBPS_500 10'h1F4
`define PMR_KBPS_1000 10'h3E8

// Chip rates in kchip/s
`define PMR_KCHIP_300 10'h12C
`define PMR_KCHIP_400 10'h190
`define PMR_KCHIP_600 10'h258
`define PMR_KCHIP_1000 10'h3E8

// Largest correctable combined frequency and symbol rate error in ppm
`define PMR_FERR_MAX_PPM 8'sh78

`endif

// ### pmr_frame_buf.sv
// Frame buffer memory with registered read data
module pmr_frame_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array, no reset needed
  logic [WIDTH-1:0] next_rdata; // Read data before the output register

  ////////////////////////////////////////////////////////////////////////////
  // Read path: address is sampled every enabled cycle
  always_comb begin
    next_rdata = mem[raddr_i];
  end

  // Read data register, cleared by reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

  // Array holds no reset so it maps onto plain RAM
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule // pmr_frame_buf

// ### pmr_host_model.sv
// Host model: serial register port master, mode 0, MSB first
module pmr_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half serial period in clocks; the port needs at least 3 per half
  localparam int half = 5;
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Lines only change just after a falling clock edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Reply bits are taken at the serial rising edge, long after they settle
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      idle(half);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      idle(half);
      sclk_o = 1'b0;
    end
  endtask
  // Command byte, then n bytes: first carries wdat, later ones zero
  task automatic transfer(input logic [7:0] cmd, input logic [7:0] wdat, input int n,
                          output logic [7:0] rbuf [16]);
    logic [7:0] junk;
    sel_n_o = 1'b0;
    idle(half);
    shift(cmd, junk);
    for (int k = 0; k < n; k++) begin
      shift((k == 0) ? wdat : 8'h00, rbuf[k]);
    end
    idle(half);
    sel_n_o = 1'b1;
    // Released data line must not keep showing stale data
    mosi_o = ~mosi_o;
    idle(half);
  endtask
endmodule // pmr_host_model

// ### pmr_pkg.sv
// Types shared by the PHY mode select block
package pmr_pkg;
  // Receive baseband top-level state, one-hot
  typedef enum logic [2:0] {
    pmr_st_off = 3'b001,
    pmr_st_listen = 3'b010,
    pmr_st_busy = 3'b100
  } pmr_rx_state_type;
endpackage

// ### pmr_top.sv
// PHY mode decoder, receive state control and serial register port
`include "pmr_defs.svh"

// Overview of operation
// R1 - Rate field zero: 100 or 250 kb/s
// R2 - Rate field one: 200 or 500 kb/s
// R3 - Rate field two: 400 or 1000 kb/s
// R4 - Rate three: reserved low, alternative 500 high
// R5 - Host write of bits 1:0 sets rate
// R6 - Bit 3 clear: BPSK 20/40, alt code
// R7 - Scrambler bit only for 400/1000 O-QPSK
// R8 - Pattern 01100 gives half-sine 250 kb/s
// R9 - Bit 4 selects raised-cosine O-QPSK shaping
// R10 - Don't-care bits and bits 7:6 ignored
// R11 - Sync and delimiter move listen to busy
// R12 - Busy receive writes payload to buffer
// R13 - Frame end returns to listening state
// R14 - Correct frequency errors up to 120 ppm
// R15 - Frame read appends quality, energy, status
// R16 - Energy and checksum flag readable
// R17 - Bit 3 picks BPSK or O-QPSK
// R18 - Bit 2 picks chip rate family
// R19 - Reserved settings still stored
module pmr_top #(
  parameter int BUF_DEPTH = 128,
  parameter int BUF_AW = 7
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic rx_enable_i,
  input wire logic rx_sync_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire logic rx_fcs_ok_i,
  input wire logic [7:0] rx_ed_i,
  input wire logic [7:0] rx_lqi_i,
  input wire logic signed [7:0] freq_err_ppm_i,
  output logic signed [7:0] freq_corr_ppm_o,
  output logic [2:0] rx_state_o,
  output logic mod_oqpsk_o,
  output logic rate_family_high_o,
  output logic [9:0] psdu_kbps_o,
  output logic [9:0] chip_kchips_o,
  output logic rc_shaping_o,
  output logic alt_spread_o,
  output logic scrambler_on_o,
  output logic mode_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sclk_sync; // [0] first stage, [1] second, [2] edge history
  logic [1:0] sel_sync; // Select, active low
  logic [1:0] mosi_sync; // Data in
  logic [2:0] next_sclk_sync;
  logic [1:0] next_sel_sync;
  logic [1:0] next_mosi_sync;
  logic sclk_rise; // Serial clock rising edge seen
  logic sclk_fall; // Serial clock falling edge seen
  logic sel_act; // Transfer in progress

  // Only stage two onward is read by logic
  always_comb begin
    next_sclk_sync = {sclk_sync[1:0], sclk_i};
    next_sel_sync = {sel_sync[0], sel_n_i};
    next_mosi_sync = {mosi_sync[0], mosi_i};
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_sync <= 3'h0;
      sel_sync <= 2'h3;
      mosi_sync <= 2'h0;
    end else if (ce_i) begin
      sclk_sync <= next_sclk_sync;
      sel_sync <= next_sel_sync;
      mosi_sync <= next_mosi_sync;
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign sel_act = ~sel_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Receive baseband state, frame buffer fill and status capture
  pmr_pkg::pmr_rx_state_type rx_state; // Top-level receive state
  pmr_pkg::pmr_rx_state_type next_rx_state;
  logic [BUF_AW-1:0] wptr; // Next buffer write slot
  logic [BUF_AW-1:0] next_wptr;
  logic [7:0] frm_len; // Bytes stored for the last frame
  logic [7:0] next_frm_len;
  logic [7:0] energy_measure_value; // Energy measured over the last frame
  logic [7:0] next_energy_measure_value;
  logic [7:0] lqi_level; // Link quality of the last frame
  logic [7:0] next_lqi_level;
  logic fcs_ok; // Checksum of the last frame was good
  logic next_fcs_ok;
  logic signed [7:0] next_freq_corr;
  logic buf_we; // Payload byte goes into the buffer
  logic [4:0] state_code; // Code shown in the state report

  // Bytes beyond the buffer are dropped rather than wrapping over the start
  always_comb begin
    next_rx_state = rx_state;
    next_wptr = wptr;
    next_frm_len = frm_len;
    next_energy_measure_value = energy_measure_value;
    next_lqi_level = lqi_level;
    next_fcs_ok = fcs_ok;
    next_freq_corr = freq_corr_ppm_o;
    buf_we = 1'b0;
    case (rx_state)
      pmr_pkg::pmr_st_off: begin
        if (rx_enable_i) begin
          next_rx_state = pmr_pkg::pmr_st_listen;
        end
      end
      pmr_pkg::pmr_st_listen: begin
        if (!rx_enable_i) begin
          next_rx_state = pmr_pkg::pmr_st_off;
        end else if (rx_sync_i) begin
          next_rx_state = pmr_pkg::pmr_st_busy; // [R11]
          next_wptr = '0;
          next_frm_len = 8'h00;
        end
      end
      pmr_pkg::pmr_st_busy: begin
        // Track the offset while a frame is being demodulated
        if (freq_err_ppm_i > `PMR_FERR_MAX_PPM) begin
          next_freq_corr = -`PMR_FERR_MAX_PPM; // [R14]
        end else if (freq_err_ppm_i < -`PMR_FERR_MAX_PPM) begin
          next_freq_corr = `PMR_FERR_MAX_PPM; // [R14]
        end else begin
          next_freq_corr = -freq_err_ppm_i; // [R14]
        end
        if (rx_byte_valid_i && (frm_len < 8'(BUF_DEPTH))) begin
          buf_we = 1'b1; // [R12]
          next_wptr = wptr + 1'b1;
          next_frm_len = frm_len + 8'h01;
        end
        if (!rx_enable_i) begin
          next_rx_state = pmr_pkg::pmr_st_off;
        end else if (rx_end_i) begin
          next_rx_state = pmr_pkg::pmr_st_listen; // [R13]
          next_energy_measure_value = rx_ed_i;
          next_lqi_level = rx_lqi_i;
          next_fcs_ok = rx_fcs_ok_i;
        end
      end
      default: begin
        next_rx_state = pmr_pkg::pmr_st_off;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state <= pmr_pkg::pmr_st_off;
      wptr <= '0;
      frm_len <= 8'h00;
      energy_measure_value <= 8'h00;
      lqi_level <= 8'h00;
      fcs_ok <= 1'b0;
      freq_corr_ppm_o <= 8'sh00;
    end else if (ce_i) begin
      rx_state <= next_rx_state;
      wptr <= next_wptr;
      frm_len <= next_frm_len;
      energy_measure_value <= next_energy_measure_value;
      lqi_level <= next_lqi_level;
      fcs_ok <= next_fcs_ok;
      freq_corr_ppm_o <= next_freq_corr;
    end
  end

  assign rx_state_o = rx_state;
  // State report code for the host
  always_comb begin
    case (rx_state)
      pmr_pkg::pmr_st_listen: state_code = `PMR_STATE_LISTEN;
      pmr_pkg::pmr_st_busy: state_code = `PMR_STATE_BUSY; // [R11]
      default: state_code = `PMR_STATE_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial register port: command byte, then address data or frame bytes
  logic [2:0] bit_cnt; // Bits of the current byte
  logic [2:0] next_bit_cnt;
  logic [1:0] byte_cnt; // Bytes in this transfer, saturates at 2
  logic [1:0] next_byte_cnt;
  logic [7:0] sh_in; // Incoming shift register
  logic [7:0] next_sh_in;
  logic [7:0] cmd; // Command byte of this transfer
  logic [7:0] next_cmd;
  logic [7:0] tx_sh; // Outgoing shift register
  logic [7:0] next_tx_sh;
  logic [7:0] fidx; // Position in the frame read stream
  logic [7:0] next_fidx;
  logic [7:0] mod_ctrl; // Modulation control register
  logic [7:0] next_mod_ctrl;
  logic next_miso_oe;
  logic [7:0] in_byte; // Byte completed by this rising edge
  logic [7:0] reg_rdata; // Register read mux
  logic [7:0] frm_byte; // Frame read stream mux
  logic [7:0] mem_rdata; // Buffer read data
  logic [BUF_AW-1:0] mem_raddr; // Buffer read address

  // Register read mux, unmapped addresses read zero
  always_comb begin
    case (cmd[5:0])
      `PMR_ADDR_STATE: reg_rdata = {3'h0, state_code}; // [R11]
      `PMR_ADDR_RSSI: reg_rdata = {fcs_ok, 7'h00}; // [R16]
      `PMR_ADDR_ED: reg_rdata = energy_measure_value; // [R16]
      `PMR_ADDR_MODCTRL: reg_rdata = mod_ctrl;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Frame stream: length, payload, then quality, energy and status trailer
  always_comb begin
    mem_raddr = BUF_AW'(fidx - 8'h01);
    if (fidx == 8'h00) begin
      frm_byte = frm_len;
    end else if (fidx <= frm_len) begin
      frm_byte = mem_rdata;
    end else if (fidx == frm_len + 8'h01) begin
      frm_byte = lqi_level; // [R15]
    end else if (fidx == frm_len + 8'h02) begin
      frm_byte = energy_measure_value; // [R15]
    end else if (fidx == frm_len + 8'h03) begin
      frm_byte = {fcs_ok, 7'h00}; // [R15]
    end else begin
      frm_byte = 8'h00;
    end
  end

  // Shift in on rising edges, shift out on falling edges
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_sh_in = sh_in;
    next_cmd = cmd;
    next_tx_sh = tx_sh;
    next_fidx = fidx;
    next_mod_ctrl = mod_ctrl;
    next_miso_oe = sel_act;
    in_byte = {sh_in[6:0], mosi_sync[1]};
    if (!sel_act) begin
      // Idle: the first byte out of a transfer is all zeros
      next_bit_cnt = 3'h0;
      next_byte_cnt = 2'h0;
      next_tx_sh = 8'h00;
      next_fidx = 8'h00;
    end else if (sclk_rise) begin
      next_sh_in = in_byte;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != 2'h2) begin
          next_byte_cnt = byte_cnt + 2'h1;
        end
        if (byte_cnt == 2'h0) begin
          next_cmd = in_byte;
          next_fidx = 8'h00;
        end else begin
          next_fidx = fidx + 8'h01;
        end
        // Every bit is kept, reserved rate combinations included
        if (byte_cnt == 2'h1 && cmd[7:6] == `PMR_CMD_WR && cmd[5:0] == `PMR_ADDR_MODCTRL) begin
          next_mod_ctrl = in_byte; // [R5] [R19]
        end
      end
    end else if (sclk_fall) begin
      if (bit_cnt == 3'h0 && byte_cnt != 2'h0) begin
        if (cmd[7:5] == `PMR_CMD_FRM) begin
          next_tx_sh = frm_byte; // [R15]
        end else if (cmd[7:6] == `PMR_CMD_RD) begin
          next_tx_sh = reg_rdata; // [R16]
        end else begin
          next_tx_sh = 8'h00;
        end
      end else begin
        next_tx_sh = {tx_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      sh_in <= 8'h00;
      cmd <= 8'h00;
      tx_sh <= 8'h00;
      fidx <= 8'h00;
      mod_ctrl <= `PMR_MODCTRL_RST;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (ce_i) begin
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      sh_in <= next_sh_in;
      cmd <= next_cmd;
      tx_sh <= next_tx_sh;
      fidx <= next_fidx;
      mod_ctrl <= next_mod_ctrl;
      miso_o <= next_tx_sh[7];
      miso_oe_o <= next_miso_oe;
    end
  end

  // Frame buffer
  pmr_frame_buf #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .we_i(buf_we),
    .waddr_i(wptr),
    .wdata_i(rx_byte_i),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // PHY mode decode from the modulation control register
  logic next_oqpsk;
  logic next_fam;
  logic [9:0] next_kbps;
  logic [9:0] next_kchips;
  logic next_rc;
  logic next_alt;
  logic next_scr;
  logic next_valid;
  logic [1:0] rate_sel; // PSDU rate field

  // Bits 7:6 never enter the decode
  always_comb begin
    rate_sel = mod_ctrl[`PMR_RATE_HI:`PMR_RATE_LO]; // [R5] [R10]
    next_oqpsk = mod_ctrl[`PMR_BIT_MOD]; // [R17]
    next_fam = mod_ctrl[`PMR_BIT_FAM]; // [R18]
    next_rc = 1'b0;
    next_alt = 1'b0;
    next_scr = 1'b0;
    next_valid = 1'b1;
    if (!next_oqpsk) begin
      // BPSK: rate field must be zero, alt code only at 40 kb/s
      next_kchips = next_fam ? `PMR_KCHIP_600 : `PMR_KCHIP_300; // [R18]
      next_kbps = next_fam ? `PMR_KBPS_40 : `PMR_KBPS_20; // [R6]
      next_alt = next_fam & mod_ctrl[`PMR_BIT_ALT]; // [R6]
      next_valid = (rate_sel == 2'h0) && (next_fam || !mod_ctrl[`PMR_BIT_ALT]); // [R6]
    end else begin
      next_kchips = next_fam ? `PMR_KCHIP_1000 : `PMR_KCHIP_400; // [R18]
      next_rc = mod_ctrl[`PMR_BIT_ALT]; // [R8] [R9]
      case (rate_sel)
        2'h0: next_kbps = next_fam ? `PMR_KBPS_250 : `PMR_KBPS_100; // [R1] [R8] [R9]
        2'h1: next_kbps = next_fam ? `PMR_KBPS_500 : `PMR_KBPS_200; // [R2]
        2'h2: begin
          next_kbps = next_fam ? `PMR_KBPS_1000 : `PMR_KBPS_400; // [R3]
          next_scr = mod_ctrl[`PMR_BIT_SCR]; // [R7]
        end
        default: begin
          next_kbps = `PMR_KBPS_500; // [R4]
          next_alt = next_fam; // [R4]
          next_valid = next_fam; // [R4] [R19]
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mod_oqpsk_o <= 1'b0;
      rate_family_high_o <= 1'b1;
      psdu_kbps_o <= `PMR_KBPS_40;
      chip_kchips_o <= `PMR_KCHIP_600;
      rc_shaping_o <= 1'b0;
      alt_spread_o <= 1'b0;
      scrambler_on_o <= 1'b0;
      mode_valid_o <= 1'b1;
    end else if (ce_i) begin
      mod_oqpsk_o <= next_oqpsk;
      rate_family_high_o <= next_fam;
      psdu_kbps_o <= next_kbps;
      chip_kchips_o <= next_kchips;
      rc_shaping_o <= next_rc;
      alt_spread_o <= next_alt;
      scrambler_on_o <= next_scr;
      mode_valid_o <= next_valid;
    end
  end
endmodule // pmr_top

// ### pmr_top_assertions.sv
// Port-level checks of the PHY mode select block
`include "pmr_defs.svh"
module pmr_top_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic rx_enable_i,
  input wire logic rx_sync_i,
  input wire logic rx_end_i,
  input wire logic signed [7:0] freq_err_ppm_i,
  input wire logic signed [7:0] freq_corr_ppm_o,
  input wire logic [2:0] rx_state_o,
  input wire logic mod_oqpsk_o,
  input wire logic rate_family_high_o,
  input wire logic [9:0] psdu_kbps_o,
  input wire logic [9:0] chip_kchips_o,
  input wire logic alt_spread_o,
  input wire logic scrambler_on_o,
  input wire logic mode_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////
  // Receive state: off 001, listen 010, busy 100, one clock after each event
  chk_sync_busy: assert property ((ce_i && rx_enable_i && rx_sync_i && rx_state_o == 3'h2)
    |=> rx_state_o == 3'h4) else $error("Sync did not enter busy");
  chk_end_listen: assert property ((ce_i && rx_enable_i && rx_end_i && rx_state_o == 3'h4)
    |=> rx_state_o == 3'h2) else $error("Frame end did not return to listen");
  chk_disable_off: assert property ((ce_i && !rx_enable_i) |=> rx_state_o == 3'h1)
    else $error("Receiver not off after disable");
  ////////////////////////////////////////////////////////////
  // Correction is the negated error, clamped, refreshed only while busy
  chk_corr_clamp: assert property ((ce_i && rx_state_o == 3'h4 && freq_err_ppm_i < 8'sh88)
    |=> freq_corr_ppm_o == 8'sh78) else $error("Correction not clamped");
  chk_corr_track: assert property ((ce_i && rx_state_o == 3'h4 && freq_err_ppm_i >= 8'sh88
    && freq_err_ppm_i <= 8'sh78) |=> freq_corr_ppm_o == -$past(freq_err_ppm_i))
    else $error("Correction does not track error");
  chk_corr_hold: assert property (rx_state_o == 3'h1 |=> $stable(freq_corr_ppm_o))
    else $error("Correction moved while off");
  ////////////////////////////////////////////////////////////
  // Decode outputs must agree with each other for every valid mode
  chk_chip_rate: assert property (mode_valid_o |-> chip_kchips_o == (mod_oqpsk_o ?
    (rate_family_high_o ? `PMR_KCHIP_1000 : `PMR_KCHIP_400) :
    (rate_family_high_o ? `PMR_KCHIP_600 : `PMR_KCHIP_300))) else $error("Chip rate wrong");
  chk_bpsk_rate: assert property ((mode_valid_o && !mod_oqpsk_o)
    |-> psdu_kbps_o == (rate_family_high_o ? `PMR_KBPS_40 : `PMR_KBPS_20)) else $error("BPSK rate wrong");
  chk_scr_gate: assert property (scrambler_on_o
    |-> mod_oqpsk_o && psdu_kbps_o inside {`PMR_KBPS_400, `PMR_KBPS_1000}) else $error("Scrambler on wrongly");
  chk_alt_gate: assert property ((alt_spread_o && mode_valid_o) |-> rate_family_high_o
    && psdu_kbps_o == (mod_oqpsk_o ? `PMR_KBPS_500 : `PMR_KBPS_40)) else $error("Alternative code wrongly");
  // Main scenarios reached
  cover property (rx_state_o == 3'h2 && rx_sync_i && rx_enable_i);
  cover property (scrambler_on_o);
  cover property (alt_spread_o && mod_oqpsk_o);
endmodule // pmr_top_assertions

bind pmr_top pmr_top_assertions pmr_top_assertions_inst (.clk_i, .nrst_i, .ce_i, .rx_enable_i, .rx_sync_i,
  .rx_end_i, .freq_err_ppm_i, .freq_corr_ppm_o, .rx_state_o, .mod_oqpsk_o, .rate_family_high_o, .psdu_kbps_o,
  .chip_kchips_o, .alt_spread_o, .scrambler_on_o, .mode_valid_o);

// ### tb.sv
// Self-checking testbench of the PHY mode select block
`include "pmr_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, nrst_i, sclk, sel_n, mosi, miso, miso_oe, rx_enable, rx_sync, rx_bv, rx_end, rx_fcs;
  logic [7:0] rx_byte, rx_ed, rx_lqi;
  logic signed [7:0] freq_err, freq_corr;
  logic [2:0] rx_state;
  logic mod_oq, fam, rc, alt, scr, valid;
  logic [9:0] kbps, kchip;
  wire miso_w;
  wire [25:0] decoded;
  int miscompares = 0;
  int checked = 0;
  // Undriven reply line floats, so it never passes for data
  assign miso_w = miso_oe ? miso : 1'bz;
  assign decoded = {kbps, kchip, mod_oq, fam, rc, alt, scr, valid};
  // Register value, payload rate, chip rate, flags oqpsk family rc alt scrambler valid
  localparam logic [33:0] mode_table [15] = '{
    {8'h08, `PMR_KBPS_100, `PMR_KCHIP_400, 6'b100001},
    {8'h0C, `PMR_KBPS_250, `PMR_KCHIP_1000, 6'b110001},
    {8'h1C, `PMR_KBPS_250, `PMR_KCHIP_1000, 6'b111001},
    {8'h09, `PMR_KBPS_200, `PMR_KCHIP_400, 6'b100001},
    {8'h0D, `PMR_KBPS_500, `PMR_KCHIP_1000, 6'b110001},
    {8'h2A, `PMR_KBPS_400, `PMR_KCHIP_400, 6'b100011},
    {8'h1A, `PMR_KBPS_400, `PMR_KCHIP_400, 6'b101001},
    {8'hFE, `PMR_KBPS_1000, `PMR_KCHIP_1000, 6'b111011},
    {8'h2F, `PMR_KBPS_500, `PMR_KCHIP_1000, 6'b110101},
    {8'h00, `PMR_KBPS_20, `PMR_KCHIP_300, 6'b000001},
    {8'h34, `PMR_KBPS_40, `PMR_KCHIP_600, 6'b010101},
    {8'hC4, `PMR_KBPS_40, `PMR_KCHIP_600, 6'b010001},
    {8'h0B, 20'h00000, 6'b000000},
    {8'h10, 20'h00000, 6'b000000},
    {8'h01, 20'h00000, 6'b000000}};
  ////////////////////////////////////////////////////////////
  pmr_top pmr_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .sclk_i(sclk), .sel_n_i(sel_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .rx_enable_i(rx_enable), .rx_sync_i(rx_sync),
    .rx_byte_valid_i(rx_bv), .rx_byte_i(rx_byte), .rx_end_i(rx_end), .rx_fcs_ok_i(rx_fcs), .rx_ed_i(rx_ed),
    .rx_lqi_i(rx_lqi), .freq_err_ppm_i(freq_err), .freq_corr_ppm_o(freq_corr), .rx_state_o(rx_state),
    .mod_oqpsk_o(mod_oq), .rate_family_high_o(fam), .psdu_kbps_o(kbps), .chip_kchips_o(kchip),
    .rc_shaping_o(rc), .alt_spread_o(alt), .scrambler_on_o(scr), .mode_valid_o(valid));
  pmr_host_model pmr_host_model_inst (.clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk), .sel_n_o(sel_n),
    .mosi_o(mosi));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  // Comparisons of port values and of register bytes
  task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Register access through the serial port
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] b [16];
    pmr_host_model_inst.transfer({`PMR_CMD_WR, a}, d, 1, b);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] b [16];
    pmr_host_model_inst.transfer({`PMR_CMD_RD, a}, 8'h00, 1, b);
    cmp_byte(b[0], exp, what);
  endtask
  ////////////////////////////////////////////////////////////
  // Reset state, reset decode (BPSK-40) and an unmapped address
  task automatic test_reset();
    cmp_port(rx_state, pmr_pkg::pmr_st_off, "state after reset");
    cmp_port(decoded, {`PMR_KBPS_40, `PMR_KCHIP_600, 6'b010001}, "reset decode");
    rd_chk(`PMR_ADDR_MODCTRL, 8'h24, "control reset value");
    rd_chk(6'h05, 8'h00, "unmapped read");
  endtask
  // Every mode of the table, reserved ones only flagged, all read back
  task automatic test_modes();
    logic [33:0] m;
    for (int i = 0; i < 15; i++) begin
      m = mode_table[i];
      reg_wr(`PMR_ADDR_MODCTRL, m[33:26]);
      if (m[0]) begin
        cmp_port(decoded, m[25:0], "mode decode");
      end else begin
        cmp_port(valid, 1'b0, "reserved flag");
      end
      rd_chk(`PMR_ADDR_MODCTRL, m[33:26], "control readback");
    end
  endtask
  // One frame: listen, busy with clamped correction, bytes, end, status reads, frame read, off
  task automatic test_receive();
    logic [7:0] b [16];
    logic [7:0] expf [8];
    expf = '{8'h04, 8'h11, 8'h22, 8'h33, 8'h44, 8'hA5, 8'h5A, 8'h80};
    rx_enable = 1'b1;
    repeat (2) @(negedge clk_i);
    cmp_port(rx_state, pmr_pkg::pmr_st_listen, "listen state");
    rd_chk(`PMR_ADDR_STATE, 8'h04, "listen report");
    freq_err = 8'sh81;
    rx_sync = 1'b1;
    @(negedge clk_i);
    rx_sync = 1'b0;
    cmp_port(rx_state, pmr_pkg::pmr_st_busy, "busy state");
    @(negedge clk_i);
    cmp_port(freq_corr, 8'sh78, "clamped correction");
    // Positive overshoot clamps to the negative limit
    freq_err = 8'sh7F;
    @(negedge clk_i);
    cmp_port(freq_corr, 8'sh88, "upper clamp");
    freq_err = 8'sh32;
    repeat (2) @(negedge clk_i);
    cmp_port(freq_corr, 8'shCE, "tracked correction");
    rd_chk(`PMR_ADDR_STATE, 8'h01, "busy report");
    // Back-to-back bytes, the last one on the end cycle
    for (int i = 1; i <= 4; i++) begin
      rx_bv = 1'b1;
      rx_byte = expf[i];
      rx_end = (i == 4);
      @(negedge clk_i);
    end
    rx_bv = 1'b0;
    rx_end = 1'b0;
    cmp_port(rx_state, pmr_pkg::pmr_st_listen, "back to listen");
    rd_chk(`PMR_ADDR_ED, 8'h5A, "energy register");
    rd_chk(`PMR_ADDR_RSSI, 8'h80, "checksum flag");
    pmr_host_model_inst.transfer({`PMR_CMD_FRM, 5'h00}, 8'h00, 8, b);
    for (int i = 0; i < 8; i++) begin
      cmp_byte(b[i], expf[i], "frame read byte");
    end
    rx_enable = 1'b0;
    repeat (2) @(negedge clk_i);
    rd_chk(`PMR_ADDR_STATE, 8'h02, "off report");
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence: reset held two cycles, synchronisers given time to settle
  initial begin
    nrst_i = 1'b0;
    {rx_enable, rx_sync, rx_bv, rx_end} = 4'h0;
    rx_fcs = 1'b1;
    rx_byte = 8'h00;
    rx_ed = 8'h5A;
    rx_lqi = 8'hA5;
    freq_err = 8'sh00;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    test_reset();
    test_modes();
    test_receive();
    print_verdict();
  end
  // Hang guard: a run past the limit counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
endmodule // tb
